// file: hw/cell_protect_pkg.sv
// constants, register map and types for the cell protection block
package cell_protect_pkg;

    // register byte offsets
    localparam logic [7:0] SLEEP_WIRE_OFS = 8'h00;
    localparam logic [7:0] HOST_TMO_OFS = 8'h04;
    localparam logic [7:0] LOW_THR_OFS = 8'h08;
    localparam logic [7:0] LOW_DLY_OFS = 8'h0c;
    localparam logic [7:0] LOW_HYST_OFS = 8'h10;
    localparam logic [7:0] NORM_WIRE_OFS = 8'h14;
    localparam logic [7:0] CONTROL_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1c;

    // reset values
    localparam logic [7:0] SLEEP_WIRE_RST = 8'h10;
    localparam logic [7:0] HOST_TMO_RST = 8'h00;
    localparam logic [15:0] LOW_THR_RST = 16'h09c4;
    localparam logic [7:0] LOW_DLY_RST = 8'h0a;
    localparam logic [1:0] LOW_HYST_RST = 2'h2;
    localparam logic [7:0] NORM_WIRE_RST = 8'h00;
    localparam logic CTRL_WD_EN_RST = 1'b1;

    // field positions
    localparam int SETTLE_LSB = 4;
    localparam int SLEEP_EN_BIT = 3;
    localparam int RATE_LSB = 0;
    localparam int CTRL_WD_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int ST_LOW_BIT = 0;
    localparam int ST_ALERT_BIT = 1;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_WIRE_BIT = 3;
    localparam int ST_SETTLE_BIT = 4;

    // value limits and decodes
    localparam logic [15:0] LOW_THR_MAX = 16'h157c;
    localparam logic [7:0] TMO_FINE_LAST = 8'h0f;
    localparam logic [9:0] TMO_COARSE_BASE = 10'h014;
    localparam logic [1:0] TMO_COARSE_SHIFT = 2'h2;
    localparam logic [15:0] HYST_50_MV = 16'h0032;
    localparam logic [15:0] HYST_100_MV = 16'h0064;
    localparam logic [15:0] HYST_200_MV = 16'h00c8;
    localparam logic [2:0] RATE_IN_BURST_FIRST = 3'h4;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;
    localparam int MS_PER_SECOND = 1000;

    typedef struct packed {
        logic [2:0] settle_code;
        logic sleep_en;
        logic [2:0] sleep_rate;
        logic [7:0] norm_time;
        logic [7:0] host_tmo;
        logic wd_en;
        logic [15:0] low_thr;
        logic [7:0] low_dly;
        logic [1:0] low_hyst;
    } cfg_type;

endpackage

// file: hw/cell_min_finder.sv
// registered minimum of all cell voltages, taken on each completed scan
`timescale 1ns/10ps
module cell_min_finder
    import cell_protect_pkg::*;
#(
    parameter int NCELLS = 5
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sample,
    input wire logic [NCELLS*16-1:0] cell_mv,
    output logic [15:0] min_mv_q,
    output logic valid_q
);

    logic [15:0] chain [NCELLS+1];

    assign chain[0] = 16'hffff;

    // running minimum across cells
    genvar g;
    generate
        for (g = 0; g < NCELLS; g++) begin : g_min
            assign chain[g+1] = (cell_mv[g*16 +: 16] < chain[g]) ? cell_mv[g*16 +: 16] : chain[g];
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            min_mv_q <= 16'hffff;
            valid_q <= 1'b0;
        end else begin
            valid_q <= sample;
            if (sample) begin
                min_mv_q <= chain[NCELLS];
            end
        end
    end

endmodule

// file: hw/cell_protect.sv
// open-wire check timing, host watchdog and cell undervoltage protection
// What this block does
// - settle delay after test current, 0..64 ms
// - enable bit gates sleep open-wire checks
// - rate codes 0-3: once per 8/4/2/1 bursts
// - rate codes 4-7: 2/4/8/16 times per burst
// - test current from every enabled cell input
// - fault when host silent for timeout; comms restart
// - alert at half the timeout, before fault; at the 1 s timeout both rise in the same cycle
// - timeout decode: 1..16 s, then 20..976 s
// - compare cells against millivolt threshold up to 5500
// - undervoltage delay counted in completed scans, 1..255
// - recover when lowest cell reaches threshold plus hysteresis, only with hysteresis on (no recovery when off)
// - hysteresis decode: off, 50, 100, 200 mV
// - normal mode: one slot, then N full scans off
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module cell_protect
    import cell_protect_pkg::*;
#(
    parameter int NCELLS = 5,
    parameter int MS_CYC = MS_CYCLES,
    parameter int MS_PER_S = MS_PER_SECOND
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_mode,
    input wire logic burst_start,
    input wire logic slot_start,
    input wire logic measurement_scan,
    input wire logic full_scan_done,
    input wire logic host_comm_seen,
    input wire logic [NCELLS-1:0] cell_in_use,
    input wire logic [NCELLS*16-1:0] cell_mv,
    output logic [NCELLS-1:0] wire_test_current,
    output logic wire_test_settling,
    output logic host_wd_alert,
    output logic host_wd_fault,
    output logic cell_low_fault
);

    cfg_type cfg_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic wr_en;
    logic clr_pulse_q;
    logic hit;
    logic [31:0] rd_d;
    logic [31:0] status_w;

    // apb: setup cycle prepares answer, access cycle completes with zero wait
    assign wr_en = psel & penable & pwrite & pready_q;

    always_comb begin
        hit = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            SLEEP_WIRE_OFS: rd_d[7:0] = {1'b0, cfg_q.settle_code, cfg_q.sleep_en, cfg_q.sleep_rate};
            HOST_TMO_OFS: rd_d[7:0] = cfg_q.host_tmo;
            LOW_THR_OFS: rd_d[15:0] = cfg_q.low_thr;
            LOW_DLY_OFS: rd_d[7:0] = cfg_q.low_dly;
            LOW_HYST_OFS: rd_d[1:0] = cfg_q.low_hyst;
            NORM_WIRE_OFS: rd_d[7:0] = cfg_q.norm_time;
            CONTROL_OFS: rd_d[CTRL_WD_EN_BIT] = cfg_q.wd_en;
            STATUS_OFS: rd_d = status_w;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~hit;
            if (psel && !penable && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg_q.settle_code <= SLEEP_WIRE_RST[SETTLE_LSB +: 3];
            cfg_q.sleep_en <= SLEEP_WIRE_RST[SLEEP_EN_BIT];
            cfg_q.sleep_rate <= SLEEP_WIRE_RST[RATE_LSB +: 3];
            cfg_q.norm_time <= NORM_WIRE_RST;
            cfg_q.host_tmo <= HOST_TMO_RST;
            cfg_q.wd_en <= CTRL_WD_EN_RST;
            cfg_q.low_thr <= LOW_THR_RST;
            cfg_q.low_dly <= LOW_DLY_RST;
            cfg_q.low_hyst <= LOW_HYST_RST;
            clr_pulse_q <= 1'b0;
        end else begin
            clr_pulse_q <= 1'b0;
            if (wr_en) begin
                case (paddr)
                    SLEEP_WIRE_OFS: begin
                        cfg_q.settle_code <= pwdata[SETTLE_LSB +: 3];
                        cfg_q.sleep_en <= pwdata[SLEEP_EN_BIT];
                        cfg_q.sleep_rate <= pwdata[RATE_LSB +: 3];
                    end
                    HOST_TMO_OFS: cfg_q.host_tmo <= pwdata[7:0];
                    LOW_THR_OFS: begin
                        cfg_q.low_thr <= (pwdata[15:0] > LOW_THR_MAX) ? LOW_THR_MAX : pwdata[15:0];
                    end
                    LOW_DLY_OFS: cfg_q.low_dly <= pwdata[7:0];
                    LOW_HYST_OFS: cfg_q.low_hyst <= pwdata[1:0];
                    NORM_WIRE_OFS: cfg_q.norm_time <= pwdata[7:0];
                    CONTROL_OFS: begin
                        cfg_q.wd_en <= pwdata[CTRL_WD_EN_BIT];
                        clr_pulse_q <= pwdata[CTRL_CLR_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // millisecond tick, restarted when a settle period begins
    logic [31:0] ms_cnt_q;
    logic ms_tick;
    logic settle_start;

    assign ms_tick = (ms_cnt_q == 32'(MS_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ms_cnt_q <= 32'h0000_0000;
        end else if (settle_start || ms_tick) begin
            ms_cnt_q <= 32'h0000_0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        end
    end

    // open-wire scheduling
    logic [2:0] burst_cnt_q;
    logic [4:0] in_burst_cnt_q;
    logic [7:0] norm_gap_q;
    logic norm_done_scan_q;
    logic wire_on_q;
    logic fire;
    logic [3:0] burst_period_mask;
    logic [4:0] per_burst;

    // bursts between activations minus one, and activations per burst
    always_comb begin
        burst_period_mask = 4'h7 >> cfg_q.sleep_rate[1:0];
        per_burst = 5'h02 << (cfg_q.sleep_rate[1:0]);
    end

    always_comb begin
        fire = 1'b0;
        if (slot_start && !wire_on_q) begin
            if (sleep_mode) begin
                if (cfg_q.sleep_en) begin
                    if (cfg_q.sleep_rate < RATE_IN_BURST_FIRST) begin
                        fire = (in_burst_cnt_q == 5'h00) && (burst_cnt_q == 3'(burst_period_mask));
                    end else begin
                        fire = (in_burst_cnt_q < per_burst);
                    end
                end
            end else begin
                fire = (cfg_q.norm_time != 8'h00) && (norm_gap_q == 8'h00) && !norm_done_scan_q;
            end
        end
    end

    assign settle_start = wire_on_q & slot_start;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            // all ones so the first burst counts as zero
            burst_cnt_q <= '1;
            in_burst_cnt_q <= 5'h00;
        end else if (burst_start) begin
            in_burst_cnt_q <= 5'h00;
            burst_cnt_q <= (in_burst_cnt_q != 5'h00) ? 3'h0 : burst_cnt_q + 3'h1;
        end else if (fire && sleep_mode) begin
            in_burst_cnt_q <= in_burst_cnt_q + 5'h01;
        end
    end

    // normal mode gap in full scans
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            norm_gap_q <= 8'h00;
            norm_done_scan_q <= 1'b0;
        end else begin
            if (measurement_scan) begin
                norm_done_scan_q <= 1'b0;
            end else if (fire && !sleep_mode) begin
                norm_done_scan_q <= 1'b1;
            end
            if (fire && !sleep_mode) begin
                norm_gap_q <= cfg_q.norm_time;
            end else if (full_scan_done && norm_gap_q != 8'h00 && !norm_done_scan_q) begin
                norm_gap_q <= norm_gap_q - 8'h01;
            end
        end
    end

    // current lasts one slot
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wire_on_q <= 1'b0;
        end else if (fire) begin
            wire_on_q <= 1'b1;
        end else if (slot_start) begin
            wire_on_q <= 1'b0;
        end
    end

    genvar c;
    generate
        for (c = 0; c < NCELLS; c++) begin : g_cur
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    wire_test_current[c] <= 1'b0;
                end else begin
                    wire_test_current[c] <= (fire | (wire_on_q & ~slot_start)) & cell_in_use[c];
                end
            end
        end
    endgenerate

    // settle delay after current switches off
    logic [6:0] settle_ms_q;
    logic [6:0] settle_len;

    assign settle_len = (cfg_q.settle_code == 3'h0) ? 7'h00 : (7'h01 << (cfg_q.settle_code - 3'h1));

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            settle_ms_q <= 7'h00;
            wire_test_settling <= 1'b0;
        end else if (settle_start) begin
            settle_ms_q <= settle_len;
            wire_test_settling <= (settle_len != 7'h00);
        end else if (ms_tick && settle_ms_q != 7'h00) begin
            settle_ms_q <= settle_ms_q - 7'h01;
            wire_test_settling <= (settle_ms_q != 7'h01);
        end
    end

    // host watchdog
    logic [9:0] ms_in_s_q;
    logic [9:0] wd_secs_q;
    logic [9:0] tmo_secs;
    logic sec_tick;

    always_comb begin
        if (cfg_q.host_tmo <= TMO_FINE_LAST) begin
            tmo_secs = {2'b00, cfg_q.host_tmo} + 10'h001;
        end else begin
            tmo_secs = TMO_COARSE_BASE + (10'({2'b00, cfg_q.host_tmo} - 10'h010) << TMO_COARSE_SHIFT);
        end
    end

    assign sec_tick = ms_tick && (ms_in_s_q == 10'(MS_PER_S - 1));

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ms_in_s_q <= 10'h000;
        end else if (host_comm_seen) begin
            ms_in_s_q <= 10'h000;
        end else if (ms_tick) begin
            ms_in_s_q <= sec_tick ? 10'h000 : ms_in_s_q + 10'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wd_secs_q <= 10'h000;
            host_wd_alert <= 1'b0;
            host_wd_fault <= 1'b0;
        end else if (host_comm_seen || !cfg_q.wd_en) begin
            wd_secs_q <= 10'h000;
            host_wd_alert <= 1'b0;
            host_wd_fault <= 1'b0;
        end else begin
            if (sec_tick && wd_secs_q != 10'h3ff) begin
                wd_secs_q <= wd_secs_q + 10'h001;
            end
            host_wd_alert <= host_wd_alert | ({1'b0, wd_secs_q, 1'b0} >= {1'b0, tmo_secs, 1'b0} >> 1);
            host_wd_fault <= host_wd_fault | (wd_secs_q >= tmo_secs);
        end
    end

    // cell undervoltage
    logic [15:0] min_mv;
    logic min_valid;
    logic [7:0] low_cnt_q;
    logic [15:0] hyst_mv;
    logic below;
    logic recover;
    logic low_set;

    cell_min_finder #(
        .NCELLS(NCELLS)
    ) u_min (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sample(measurement_scan),
        .cell_mv(cell_mv),
        .min_mv_q(min_mv),
        .valid_q(min_valid)
    );

    always_comb begin
        case (cfg_q.low_hyst)
            2'h1: hyst_mv = HYST_50_MV;
            2'h2: hyst_mv = HYST_100_MV;
            2'h3: hyst_mv = HYST_200_MV;
            default: hyst_mv = 16'h0000;
        endcase
    end

    assign below = min_mv < cfg_q.low_thr;
    assign low_set = min_valid && below && ({1'b0, low_cnt_q} + 9'h001 >= {1'b0, cfg_q.low_dly});
    assign recover = min_valid && (cfg_q.low_hyst != 2'h0)
        && ({1'b0, min_mv} >= {1'b0, cfg_q.low_thr} + {1'b0, hyst_mv});

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            low_cnt_q <= 8'h00;
        end else if (min_valid) begin
            if (!below) begin
                low_cnt_q <= 8'h00;
            end else if (low_cnt_q != 8'hff) begin
                low_cnt_q <= low_cnt_q + 8'h01;
            end
        end
    end

    // set wins over any clear
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cell_low_fault <= 1'b0;
        end else if (low_set) begin
            cell_low_fault <= 1'b1;
        end else if (recover || clr_pulse_q) begin
            cell_low_fault <= 1'b0;
        end
    end

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[ST_LOW_BIT] = cell_low_fault;
        status_w[ST_ALERT_BIT] = host_wd_alert;
        status_w[ST_FAULT_BIT] = host_wd_fault;
        status_w[ST_WIRE_BIT] = wire_on_q;
        status_w[ST_SETTLE_BIT] = wire_test_settling;
    end

endmodule

// file: testbench/cell_protect_monitor.sv
// port checker for the cell protection block
`timescale 1ns/10ps
module cell_protect_monitor #(
    parameter int NCELLS = 5
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slot_start,
    input wire logic measurement_scan,
    input wire logic host_comm_seen,
    input wire logic [NCELLS-1:0] cell_in_use,
    input wire logic [NCELLS-1:0] wire_test_current,
    input wire logic wire_test_settling,
    input wire logic host_wd_alert,
    input wire logic host_wd_fault,
    input wire logic cell_low_fault
);
    logic [3:0] since_scan_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // cycles since the last completed scan
    always_ff @(posedge sys_clk) begin
        if (!rstn || measurement_scan) begin
            since_scan_q <= 4'h0;
        end else if (since_scan_q != 4'hf) begin
            since_scan_q <= since_scan_q + 4'h1;
        end
    end
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_wire_enabled_only: assert property ((wire_test_current & ~$past(cell_in_use)) == '0)
        else $error("current on unused cell");
    a_wire_on_slot: assert property ($rose(|wire_test_current) |-> $past(slot_start))
        else $error("current began off slot");
    a_settle_after_off: assert property ($rose(wire_test_settling) |-> $past(|wire_test_current))
        else $error("settling without current");
    a_comm_clears_fault: assert property (host_comm_seen |=> !host_wd_fault)
        else $error("fault kept after comms");
    a_comm_clears_alert: assert property (host_comm_seen |-> ##2 !host_wd_alert)
        else $error("alert kept after comms");
    a_alert_before_fault: assert property ($rose(host_wd_fault) |-> ##[0:1] host_wd_alert)
        else $error("fault without alert");
    a_low_near_scan: assert property ($rose(cell_low_fault) |-> since_scan_q <= 4'h3)
        else $error("low fault away from scan");
    c_low_fault: cover property ($rose(cell_low_fault));
    c_wd_fault: cover property ($rose(host_wd_fault));
    c_settle: cover property ($rose(wire_test_settling));
endmodule

bind cell_protect cell_protect_monitor #(.NCELLS(NCELLS)) u_monitor (.sys_clk(sys_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .slot_start(slot_start),
    .measurement_scan(measurement_scan), .host_comm_seen(host_comm_seen), .cell_in_use(cell_in_use),
    .wire_test_current(wire_test_current), .wire_test_settling(wire_test_settling),
    .host_wd_alert(host_wd_alert), .host_wd_fault(host_wd_fault), .cell_low_fault(cell_low_fault));

// file: testbench/host_link_model.sv
// host side model: periodic or requested communication pulses
`timescale 1ns/10ps
module host_link_model #(
    parameter int PERIOD = 30
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic quiet,
    input wire logic send_now,
    output logic host_comm_seen
);
    int gap_q;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            gap_q <= 0;
            host_comm_seen <= 1'b0;
        end else begin
            gap_q <= (gap_q == PERIOD - 1) ? 0 : gap_q + 1;
            host_comm_seen <= send_now || (!quiet && gap_q == PERIOD - 1);
        end
    end
endmodule

// file: testbench/cell_protect_config_test.sv
// self-checking bench for the cell protection block
`timescale 1ns/10ps
module cell_protect_config_test;
    import cell_protect_pkg::*;
    localparam int NC = 5;
    localparam int MSC = 10, MSS = 5, SEC = MSC * MSS;
    logic sys_clk = 1'b0;
    logic rstn, psel, penable, pwrite, sleep_mode, burst_start, slot_start, measurement_scan;
    logic full_scan_done, quiet, send_now, host_comm_seen, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NC-1:0] cell_in_use, wire_test_current;
    logic [NC*16-1:0] cell_mv;
    logic wire_test_settling, host_wd_alert, host_wd_fault, cell_low_fault;
    integer fails = 0, compares = 0, seed = 97, bc, p, act, cnt, lowf, mn, i, j, n;
    int mins[$] = '{2400, 2400, 2600, 2400, 2400, 2400, 2520, 2549, 2550, 2499};
    logic [31:0] rst_tab[5] = '{32'h10, 32'h0, 32'h9c4, 32'ha, 32'h2};
    logic [7:0] wire_tab[6] = '{8'h1b, 8'h1a, 8'h19, 8'h18, 8'h2e, 8'h13};
    always #5 sys_clk = ~sys_clk;
    cell_protect #(.NCELLS(NC), .MS_CYC(MSC), .MS_PER_S(MSS)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode), .burst_start(burst_start),
        .slot_start(slot_start), .measurement_scan(measurement_scan), .full_scan_done(full_scan_done),
        .host_comm_seen(host_comm_seen), .cell_in_use(cell_in_use), .cell_mv(cell_mv),
        .wire_test_current(wire_test_current), .wire_test_settling(wire_test_settling),
        .host_wd_alert(host_wd_alert), .host_wd_fault(host_wd_fault), .cell_low_fault(cell_low_fault));
    host_link_model #(.PERIOD(30)) host (.sys_clk(sys_clk), .rstn(rstn), .quiet(quiet),
        .send_now(send_now), .host_comm_seen(host_comm_seen));
    task automatic tk(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tk(1);
        penable <= 1'b1;
        k = 0;
        do begin
            tk(1);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tk(1);
        if (k >= 20) begin
            fails++;
            tally_and_finish;
        end
    endtask
    initial begin
        {rstn, psel, penable, pwrite, sleep_mode, burst_start, slot_start} = '0;
        {measurement_scan, full_scan_done, quiet, send_now, paddr, pwdata} = '0;
        cell_in_use = NC'($random(seed)) | NC'(1);
        cell_mv = {NC{16'h0bb8}};
        tk(8);
        rstn <= 1'b1;
        tk(1);
        for (i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, rd, err);
            check("reset value", rd, rst_tab[i]);
        end
        apb(1'b0, 8'h20, 32'h0, rd, err);
        check("unmapped error", 32'(err), 32'h1);
        n = $random(seed);
        apb(1'b1, LOW_DLY_OFS, 32'(n[7:0]), rd, err);
        apb(1'b0, LOW_DLY_OFS, 32'h0, rd, err);
        check("delay readback", rd, 32'(n[7:0]));
        apb(1'b1, LOW_THR_OFS, 32'hffff, rd, err);
        apb(1'b0, LOW_THR_OFS, 32'h0, rd, err);
        check("threshold clamp", rd, 32'd5500);
        // undervoltage persistence and recovery
        apb(1'b1, LOW_THR_OFS, 32'd2500, rd, err);
        apb(1'b1, LOW_DLY_OFS, 32'h3, rd, err);
        apb(1'b1, LOW_HYST_OFS, 32'h1, rd, err);
        cnt = 0;
        lowf = 0;
        foreach (mins[k]) begin
            mn = mins[k];
            j = $unsigned($random(seed)) % NC;
            for (i = 0; i < NC; i++) begin
                cell_mv[16*i +: 16] <= 16'(i == j ? mn : mn + $unsigned($random(seed)) % 300);
            end
            measurement_scan <= 1'b1;
            tk(1);
            measurement_scan <= 1'b0;
            if (mn < 2500) begin
                cnt++;
                if (cnt >= 3) lowf = 1;
            end else begin
                cnt = 0;
                if (mn >= 2550) lowf = 0;
            end
            tk(4);
            check("low fault", 32'(cell_low_fault), 32'(lowf));
        end
        // sleep open-wire schedule per rate code
        sleep_mode <= 1'b1;
        bc = 0;
        for (i = 0; i < 6; i++) begin
            apb(1'b1, SLEEP_WIRE_OFS, 32'(wire_tab[i]), rd, err);
            p = 8 >> wire_tab[i][2:0];
            for (j = 0; j < 8; j++) begin
                act = (wire_tab[i][3] && (wire_tab[i][2] || bc == p - 1)) ? 1 : 0;
                bc = act ? 0 : bc + 1;
                burst_start <= 1'b1;
                tk(1);
                burst_start <= 1'b0;
                tk(1);
                slot_start <= 1'b1;
                tk(1);
                slot_start <= 1'b0;
                tk(2);
                check("wire current", 32'(wire_test_current), act ? 32'(cell_in_use) : 32'h0);
                slot_start <= 1'b1;
                tk(1);
                slot_start <= 1'b0;
                tk(2);
                check("settling", 32'(wire_test_settling), 32'(act));
                tk(22);
                check("settled", 32'(wire_test_settling), 32'h0);
            end
        end
        // normal mode: one slot per scan, then two full scans off
        sleep_mode <= 1'b0;
        apb(1'b1, NORM_WIRE_OFS, 32'h2, rd, err);
        bc = 0;
        for (j = 0; j < 6; j++) begin
            slot_start <= 1'b1;
            tk(1);
            slot_start <= 1'b0;
            tk(2);
            check("normal current", 32'(wire_test_current), bc == 0 ? 32'(cell_in_use) : 32'h0);
            slot_start <= 1'b1;
            tk(1);
            {slot_start, measurement_scan, full_scan_done} <= 3'b011;
            tk(1);
            {measurement_scan, full_scan_done} <= 2'b00;
            tk(14);
            bc = (bc == 0) ? 2 : bc - 1;
        end
        // watchdog alert at half, fault at full timeout; fine and coarse codes
        quiet <= 1'b1;
        for (i = 0; i < 2; i++) begin
            p = i ? 20 : 2;
            apb(1'b1, HOST_TMO_OFS, i ? 32'h10 : 32'h1, rd, err);
            send_now <= 1'b1;
            tk(1);
            send_now <= 1'b0;
            n = 0;
            while (host_wd_alert !== 1'b1 && n < 1100) begin
                tk(1);
                n++;
            end
            // restart is exact to one millisecond tick
            check("alert time", 32'(n >= p * SEC / 2 - 6 && n <= p * SEC / 2 + 3), 32'h1);
            while (host_wd_fault !== 1'b1 && n < 1100) begin
                tk(1);
                n++;
            end
            check("fault time", 32'(n >= p * SEC - 6 && n <= p * SEC + 3), 32'h1);
            if (n >= 1100) tally_and_finish;
            send_now <= 1'b1;
            tk(1);
            send_now <= 1'b0;
            tk(4);
            check("watchdog cleared", 32'({host_wd_alert, host_wd_fault}), 32'h0);
        end
        tally_and_finish;
    end
endmodule
